//--- rtl/adc_control_regs.sv
// Control, output format and map checksum registers of the converter, AXI4-Lite slave.
// Assumes one clock; the serial clock and trim fault arrive from outside it.
//
// Overview of operation
// - Host and device use polynomial x16+x14+x13+x12+x10+x8+x6+x4+x3+x+1.
// - Each checksum pass starts from seed 0xFFFF.
// - Device re-walks the covered range endlessly and compares with the reference.
// - A mismatch sets the sticky map error flag; writing one clears it.
// - Self-test bit 7 injects an error into trim and map checks.
// - Control bit 4, reset one, enables LVDS input termination.
// - Control bit 3 selects half-bias LVDS drive; reset is normal drive.
// - Control bit 2 powers down the reference buffer; reset zero.
// - Control bit 1 selects external reference; zero keeps internal.
// - Control bit 0, reset one, echoes the serial clock back out.
// - Format bit 2 replaces conversion packets with per-channel fixed patterns.
// - The pattern applies to both the CMOS and LVDS output buses.
// - Format bits 1:0 pick 16-bit (00) or 24-bit (01) packets; reset 01.
// - Packet layout depends on size, oversampling and pattern enable.
`timescale 1ns/1ps
`default_nettype none
`include "adc_regs_params.svh"
module adc_control_regs
  import adc_regs_pkg::*;
(
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  // AXI4-Lite write address
  input  wire logic [`AXI_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  // AXI4-Lite read
  input  wire logic [`AXI_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  // Device side
  input  wire logic                   serial_clock_input,
  input  wire logic                   trim_check_fail,
  input  wire logic                   oversample_mode,
  output logic                        returned_serial_clock,
  output logic                        checksum_self_test,
  output logic                        lvds_termination_enable,
  output logic                        lvds_half_bias,
  output logic                        reference_buffer_off,
  output logic                        external_reference_select,
  output logic                        fixed_pattern_enable,
  output logic [1:0]                  packet_size,
  output logic [2:0]                  packet_layout,
  output logic                        irq
);
  logic                  aw_held;
  logic                  w_held;
  logic [`IDX_W-1:0]     aw_idx;
  logic [7:0]            w_byte;
  logic                  w_lane0;
  logic                  do_write;
  logic                  wr_ok;
  logic [`IDX_W-1:0]     ar_idx;
  logic                  rd_stage;
  logic [7:0]            mem_rdata;
  logic [7:0]            rd_byte;
  logic [15:0]           map_checksum_value;
  logic [7:0]            status;
  logic [7:0]            irq_enable;
  logic [7:0]            ctrl_byte;
  logic [7:0]            fmt_byte;
  logic                  sck_meta;
  logic                  sck_sync;
  logic                  trim_meta;
  logic                  trim_sync;
  logic                  check_done;
  logic                  mismatch;
  logic [7:0]            next_set;
  logic [7:0]            next_clr;

  scan_if scan ();

  // Decode of mapped indices; anything else answers SLVERR
  function automatic logic idx_mapped(input logic [`IDX_W-1:0] i);
    return ((i >= `IDX_CRC_LO) && (i <= `IDX_MAP_TOP)) ||
           ((i >= `IDX_STATUS) && (i <= `IDX_IRQ_CLR));
  endfunction

  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign wr_ok    = do_write && w_lane0;

  // Write channels are taken in either order; one write is open at a time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_idx        <= '0;
      w_byte        <= 8'h00;
      w_lane0       <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held       <= 1'b1;
        aw_idx        <= s_axi_awaddr[`AXI_ADDR_W-1:2];
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held       <= 1'b1;
        w_byte       <= s_axi_wdata[7:0];
        w_lane0      <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= idx_mapped(aw_idx) ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Device control register, each field straight out of its flop
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      checksum_self_test        <= 1'(`CTRL_RESET >> `CTRL_SELF_TEST);
      lvds_termination_enable   <= 1'(`CTRL_RESET >> `CTRL_TERM);
      lvds_half_bias            <= 1'(`CTRL_RESET >> `CTRL_HALF_BIAS);
      reference_buffer_off      <= 1'(`CTRL_RESET >> `CTRL_BUFFERED_REFERENCE_PIN);
      external_reference_select <= 1'(`CTRL_RESET >> `CTRL_REF_SEL);
      returned_serial_clock     <= 1'b0;
    end else begin
      if (wr_ok && (aw_idx == `IDX_DEV_CTRL)) begin
        checksum_self_test        <= w_byte[`CTRL_SELF_TEST];
        lvds_termination_enable   <= w_byte[`CTRL_TERM];
        lvds_half_bias            <= w_byte[`CTRL_HALF_BIAS];
        reference_buffer_off      <= w_byte[`CTRL_BUFFERED_REFERENCE_PIN];
        external_reference_select <= w_byte[`CTRL_REF_SEL];
      end
      // Echo follows the sampled serial clock three cycles late: two of sync, one of this flop
      returned_serial_clock <= ctrl_byte[`CTRL_ECHO] & sck_sync;
    end
  end

  // Echo enable kept apart from the echo flop so readback sees the setting
  logic clock_return_enable;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clock_return_enable <= 1'(`CTRL_RESET >> `CTRL_ECHO);
    end else if (wr_ok && (aw_idx == `IDX_DEV_CTRL)) begin
      clock_return_enable <= w_byte[`CTRL_ECHO];
    end
  end

  // Readback images; reserved bits are forced to zero
  always_comb begin
    ctrl_byte = 8'h00;
    ctrl_byte[`CTRL_SELF_TEST] = checksum_self_test;
    ctrl_byte[`CTRL_TERM]      = lvds_termination_enable;
    ctrl_byte[`CTRL_HALF_BIAS] = lvds_half_bias;
    ctrl_byte[`CTRL_BUFFERED_REFERENCE_PIN]    = reference_buffer_off;
    ctrl_byte[`CTRL_REF_SEL]   = external_reference_select;
    ctrl_byte[`CTRL_ECHO]      = clock_return_enable;
    ctrl_byte = ctrl_byte & `CTRL_MASK;
    fmt_byte  = {5'h00, fixed_pattern_enable, packet_size} & `FMT_MASK;
  end

  // Output format register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fixed_pattern_enable <= 1'(`FMT_RESET >> `FMT_PATTERN);
      packet_size          <= 2'(`FMT_RESET);
    end else if (wr_ok && (aw_idx == `IDX_OUT_FMT)) begin
      fixed_pattern_enable <= w_byte[`FMT_PATTERN];
      // Codes 10 and 11 are stored as written; the host keeps clear of them
      packet_size <= w_byte[`FMT_SIZE_MSB:`FMT_SIZE_LSB];
    end
  end

  // One layout code drives both the CMOS and the LVDS packers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      packet_layout <= LAYOUT_CONV24;
    end else begin
      packet_layout <= {oversample_mode, fixed_pattern_enable, packet_size[`FMT_SIZE_LSB]};
    end
  end

  // Reference checksum, written a byte at a time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      map_checksum_value <= `CRC_REF_RESET;
    end else if (wr_ok && (aw_idx == `IDX_CRC_LO)) begin
      map_checksum_value[7:0] <= w_byte;
    end else if (wr_ok && (aw_idx == `IDX_CRC_HI)) begin
      map_checksum_value[15:8] <= w_byte;
    end
  end

  // Serial clock and trim fault pass two flops before anything reads them
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sck_meta  <= 1'b0;
      sck_sync  <= 1'b0;
      trim_meta <= 1'b0;
      trim_sync <= 1'b0;
    end else begin
      sck_meta  <= serial_clock_input;
      sck_sync  <= sck_meta;
      trim_meta <= trim_check_fail;
      trim_sync <= trim_meta;
    end
  end

  // Flag events; self-test also fails the trim check at every compare
  always_comb begin
    next_set = 8'h00;
    next_set[`ST_MAP_ERR]  = check_done && mismatch;
    next_set[`ST_TRIM_ERR] = trim_sync || (check_done && checksum_self_test);
    next_clr = (wr_ok && (aw_idx == `IDX_IRQ_CLR)) ? (w_byte & `ST_MASK) : 8'h00;
  end

  // Sticky status: an event in the clearing cycle wins over the clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status <= 8'h00;
    end else begin
      status <= (status & ~next_clr) | next_set;
    end
  end

  // Interrupt enable and the level interrupt line
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_enable <= 8'h00;
      irq        <= 1'b0;
    end else begin
      if (wr_ok && (aw_idx == `IDX_IRQ_EN)) begin
        irq_enable <= w_byte & `ST_MASK;
      end
      irq <= |(status & irq_enable);
    end
  end

  // Readback mux; clear register reads zero
  always_comb begin
    unique case (ar_idx)
      `IDX_CRC_LO:   rd_byte = map_checksum_value[7:0];
      `IDX_CRC_HI:   rd_byte = map_checksum_value[15:8];
      `IDX_DEV_CTRL: rd_byte = ctrl_byte;
      `IDX_OUT_FMT:  rd_byte = fmt_byte;
      `IDX_STATUS:   rd_byte = status;
      `IDX_IRQ_EN:   rd_byte = irq_enable;
      default:       rd_byte = (ar_idx <= `IDX_MAP_TOP) ? mem_rdata : 8'h00;
    endcase
  end

  // Read: store latches the address at the handshake, data leave one cycle on
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `RESP_OKAY;
      ar_idx        <= '0;
      rd_stage      <= 1'b0;
    end else begin
      rd_stage <= 1'b0;
      if (s_axi_arvalid && s_axi_arready) begin
        ar_idx        <= s_axi_araddr[`AXI_ADDR_W-1:2];
        s_axi_arready <= 1'b0;
        rd_stage      <= 1'b1;
      end
      if (rd_stage) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h00_0000, idx_mapped(ar_idx) ? rd_byte : 8'h00};
        s_axi_rresp  <= idx_mapped(ar_idx) ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // Covered bytes other than the two control bytes live in the store
  map_byte_store u_store (
    .aclk      (aclk),
    .we        (wr_ok && (aw_idx > `IDX_OUT_FMT) && (aw_idx <= `IDX_MAP_TOP)),
    .waddr     (aw_idx[6:0]),
    .wdata     (w_byte),
    .raddr     (s_axi_araddr[8:2]),
    .rdata     (mem_rdata),
    .ctrl_byte (ctrl_byte),
    .fmt_byte  (fmt_byte),
    .scan      (scan.store)
  );

  // Continuous map checksum against the programmed reference
  map_checksum_engine u_engine (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .scan       (scan.engine),
    .reference  (map_checksum_value),
    .inject     (checksum_self_test),
    .check_done (check_done),
    .mismatch   (mismatch)
  );
endmodule
`default_nettype wire

//--- rtl/adc_regs_params.svh
// Constants of the converter control and map checksum register block.
// Assumes inclusion by bare name from every file that needs an offset or count.
`ifndef ADC_REGS_PARAMS_SVH
`define ADC_REGS_PARAMS_SVH

// Register indices; byte address is four times the index
`define IDX_W          8
`define IDX_CRC_LO     8'h23
`define IDX_CRC_HI     8'h24
`define IDX_DEV_CTRL   8'h25
`define IDX_OUT_FMT    8'h26
`define IDX_MAP_TOP    8'h71
`define IDX_STATUS     8'h80
`define IDX_IRQ_EN     8'h81
`define IDX_IRQ_CLR    8'h82

// Device control fields and reset value
`define CTRL_SELF_TEST 7
`define CTRL_TERM      4
`define CTRL_HALF_BIAS 3
`define CTRL_BUFFERED_REFERENCE_PIN    2
`define CTRL_REF_SEL   1
`define CTRL_ECHO      0
`define CTRL_RESET     8'h11
`define CTRL_MASK      8'h9F

// Output format fields and reset value
`define FMT_PATTERN    2
`define FMT_SIZE_MSB   1
`define FMT_SIZE_LSB   0
`define FMT_RESET      8'h01
`define FMT_MASK       8'h07

// Status flag positions, shared by status, enable and clear
`define ST_TRIM_ERR    5
`define ST_MAP_ERR     4
`define ST_MASK        8'h30

// Checksum engine
`define CRC_POLY       16'h755B
`define CRC_SEED       16'hFFFF
`define CRC_REF_RESET  16'h0000
`define SCAN_HI        7'h71
`define SCAN_LO        7'h25

// AXI4-Lite
`define AXI_ADDR_W     10
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2

`endif

//--- rtl/adc_regs_pkg.sv
// Types shared by the control register block and its checksum engine.
// Assumes adc_regs_params.svh carries every numeric constant.
package adc_regs_pkg;

  // Checksum scan sequencer
  typedef enum logic [1:0] {
    SCAN_ISSUE = 2'b00,
    SCAN_TAKE  = 2'b01,
    SCAN_CHECK = 2'b10
  } scan_state_t;

  // Output packet layout: {oversampling, pattern, 24-bit}
  typedef enum logic [2:0] {
    LAYOUT_CONV16    = 3'b000,
    LAYOUT_CONV24    = 3'b001,
    LAYOUT_PAT16     = 3'b010,
    LAYOUT_PAT24     = 3'b011,
    LAYOUT_OS_CONV16 = 3'b100,
    LAYOUT_OS_CONV24 = 3'b101,
    LAYOUT_OS_PAT16  = 3'b110,
    LAYOUT_OS_PAT24  = 3'b111
  } layout_t;

endpackage

//--- rtl/scan_if.sv
// Byte fetch path between the checksum engine and the register byte store.
// Assumes one registered read: data answers the address of the previous cycle.
`timescale 1ns/1ps
`default_nettype none
interface scan_if;
  logic [6:0] addr;
  logic [7:0] data;

  modport engine (output addr, input data);
  modport store  (input addr, output data);
endinterface
`default_nettype wire

//--- rtl/map_byte_store.sv
// Byte store for the covered map range, with a bus read port and a scan port.
// Assumes the two control bytes live in flops outside and arrive as inputs.
`timescale 1ns/1ps
`default_nettype none
`include "adc_regs_params.svh"
module map_byte_store (
  input  wire logic       aclk,
  input  wire logic       we,
  input  wire logic [6:0] waddr,
  input  wire logic [7:0] wdata,
  input  wire logic [6:0] raddr,
  output logic      [7:0] rdata,
  input  wire logic [7:0] ctrl_byte,
  input  wire logic [7:0] fmt_byte,
  scan_if.store           scan
);
  logic [7:0] mem [0:127];

  // Plain write port; contents are not reset, software programs them
  always_ff @(posedge aclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // Bus read port, registered
  always_ff @(posedge aclk) begin
    rdata <= mem[raddr];
  end

  // Scan read port; control bytes come from their live flops
  always_ff @(posedge aclk) begin
    if (scan.addr == `IDX_DEV_CTRL) begin
      scan.data <= ctrl_byte;
    end else if (scan.addr == `IDX_OUT_FMT) begin
      scan.data <= fmt_byte;
    end else begin
      scan.data <= mem[scan.addr];
    end
  end
endmodule
`default_nettype wire

//--- rtl/map_checksum_engine.sv
// Endless checksum walk over the map from the top index down to the control byte.
// Assumes a store that answers each address one cycle later.
`timescale 1ns/1ps
`default_nettype none
`include "adc_regs_params.svh"
module map_checksum_engine
  import adc_regs_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  scan_if.engine           scan,
  input  wire logic [15:0] reference,
  input  wire logic        inject,
  output logic             check_done,
  output logic             mismatch
);
  scan_state_t state;
  logic [15:0] crc;

  // One byte, most significant bit first
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    logic        fb;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      fb = r[15] ^ d[i];
      r  = {r[14:0], 1'b0};
      if (fb) begin
        r = r ^ `CRC_POLY;
      end
    end
    return r;
  endfunction

  // Walk sequencer; a new pass starts the cycle after each compare
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state      <= SCAN_ISSUE;
      scan.addr  <= `SCAN_HI;
      crc        <= `CRC_SEED;
      check_done <= 1'b0;
      mismatch   <= 1'b0;
    end else begin
      check_done <= 1'b0;
      mismatch   <= 1'b0;
      unique case (state)
        SCAN_ISSUE: begin
          state <= SCAN_TAKE;
        end
        SCAN_TAKE: begin
          crc <= crc_byte(crc, scan.data);
          if (scan.addr == `SCAN_LO) begin
            state <= SCAN_CHECK;
          end else begin
            scan.addr <= scan.addr - 7'h01;
            state     <= SCAN_ISSUE;
          end
        end
        SCAN_CHECK: begin
          // Injection flips the low bit so the compare must fail
          check_done <= 1'b1;
          mismatch   <= ({crc[15:1], crc[0] ^ inject} != reference);
          crc        <= `CRC_SEED;
          scan.addr  <= `SCAN_HI;
          state      <= SCAN_ISSUE;
        end
        default: begin
          state <= SCAN_ISSUE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

//--- test/adc_regs_assertions.sv
// Port-level checker of the control register block.
// Assumes one clock domain and the synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module adc_regs_assertions (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wvalid,
  input wire logic       s_axi_wready,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  input wire logic       s_axi_rready,
  input wire logic       serial_clock_input,
  input wire logic       oversample_mode,
  input wire logic       returned_serial_clock,
  input wire logic       checksum_self_test,
  input wire logic       lvds_termination_enable,
  input wire logic       lvds_half_bias,
  input wire logic       reference_buffer_off,
  input wire logic       external_reference_select,
  input wire logic       fixed_pattern_enable,
  input wire logic [1:0] packet_size,
  input wire logic [2:0] packet_layout
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Both halves of a write taken at one edge
  sequence write_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // Read data after one internal stage
  sequence read_answer;
    !s_axi_rvalid ##1 s_axi_rvalid;
  endsequence

  reset_image_a: assert property (
    $rose(aresetn) |-> lvds_termination_enable && !lvds_half_bias && !reference_buffer_off
      && !external_reference_select && !checksum_self_test && packet_size == 2'h1)
    else $error("reset image");
  layout_track_a: assert property (
    packet_layout == {$past(oversample_mode), $past(fixed_pattern_enable), $past(packet_size[0])})
    else $error("layout stale");
  echo_source_a: assert property (
    returned_serial_clock |-> $past(serial_clock_input, 3))
    else $error("echo without input");
  size_legal_a: assert property (!packet_size[1])
    else $error("reserved packet size shown");
  write_answer_a: assert property (write_taken |-> ##2 s_axi_bvalid)
    else $error("write response late");
  write_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while busy");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> read_answer)
    else $error("read answer late");
  read_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read not freed");
endmodule
bind adc_control_regs adc_regs_assertions chk_u (.*);
`default_nettype wire

//--- test/serial_far_side.sv
// Far-side model: serial clock source and trim check fault source.
// Assumes the bench opens and closes serial clock frames.
`timescale 1ns/1ps
`default_nettype none
module serial_far_side (
  input  wire logic aclk,
  input  wire logic run,
  input  wire logic fault_req,
  output logic      serial_clock_input,
  output logic      trim_check_fail
);
  logic [1:0] div = 2'h0;
  // Clock stands low outside a frame, so no stray edge reaches the echo path
  always @(posedge aclk) begin
    div <= (div == 2'h2) ? 2'h0 : div + 2'h1;
    if (!run) serial_clock_input <= 1'b0;
    else if (div == 2'h2) serial_clock_input <= ~serial_clock_input;
    trim_check_fail <= fault_req;
  end
endmodule
`default_nettype wire

//--- test/adc_control_and_map_checksum_regs_tb.sv
// Bench for the control register block, driven over AXI4-Lite.
// Assumes the far-side model supplies the serial clock and trim fault.
`timescale 1ns/1ps
`default_nettype none
`include "adc_regs_params.svh"
module adc_control_and_map_checksum_regs_tb;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, serial_clock_input, trim_check_fail, oversample_mode;
  logic        returned_serial_clock, checksum_self_test, lvds_termination_enable;
  logic        lvds_half_bias, reference_buffer_off, external_reference_select;
  logic        fixed_pattern_enable, irq, clk_run, fault_req;
  logic [9:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, packet_size;
  logic [2:0]  packet_layout;
  logic [4:0]  ctl_pins;
  logic [7:0]  img [8'h25:8'h71];
  int          err_total, n_checks, cyc;

  assign ctl_pins = {checksum_self_test, lvds_termination_enable, lvds_half_bias,
                     reference_buffer_off, external_reference_select};
  adc_control_regs dut_u (.*);
  serial_far_side far_u (.aclk, .run(clk_run), .fault_req, .serial_clock_input, .trim_check_fail);

  always #2 aclk = ~aclk;

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Ceiling far above the test length
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      $display("[ERR] %0t timeout", $time);
      stop_test();
    end
  end

  task automatic chk_word(input logic [31:0] g, input logic [31:0] e, input string m);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  task automatic chk_resp(input logic [1:0] g, input logic [1:0] e, input string m);
    chk_word(32'(g), 32'(e), {m, " resp"});
  endtask

  // Each answer is taken at the edge it is seen
  task automatic wr(input logic [7:0] idx, input logic [7:0] d, output logic [1:0] r);
    logic aw = 0, w = 0;
    s_axi_awaddr <= {idx, 2'h0};
    s_axi_wdata <= 32'(d);
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (!aw && s_axi_awready === 1'b1) begin
        aw = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w && s_axi_wready === 1'b1) begin
        w = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
  endtask

  task automatic rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= {idx, 2'h0};
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask

  task automatic wr_ok(input logic [7:0] idx, input logic [7:0] d);
    logic [1:0] r;
    wr(idx, d, r);
    chk_resp(r, `RESP_OKAY, "write");
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] e, input string m);
    logic [31:0] d;
    logic [1:0]  r;
    rd(idx, d, r);
    chk_resp(r, `RESP_OKAY, m);
    chk_word(d, e, m);
  endtask

  // Map checksum of one byte, MSB first
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
    c = c ^ {b, 8'h00};
    for (int k = 0; k < 8; k++) c = c[15] ? ((c << 1) ^ 16'h755B) : (c << 1);
    return c;
  endfunction

  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    logic [15:0] crc;
    logic [7:0]  v;
    logic        seen;
    logic [7:0]  cv [4] = '{8'h6A, 8'h1F, 8'h0E, 8'h11};
    logic [7:0]  fv [4] = '{8'hFC, 8'h05, 8'h00, 8'h01};
    {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, oversample_mode} = '0;
    {clk_run, fault_req, s_axi_awaddr, s_axi_araddr, s_axi_wdata, cyc} = '0;
    {s_axi_bready, s_axi_rready, s_axi_wstrb} = '1;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd_chk(`IDX_DEV_CTRL, 32'h11, "ctrl reset");
    rd_chk(`IDX_OUT_FMT, 32'h01, "fmt reset");
    rd_chk(`IDX_CRC_LO, 32'h00, "ref low reset");
    rd_chk(`IDX_CRC_HI, 32'h00, "ref high reset");
    chk_word(32'({packet_layout, packet_size, ctl_pins}), 32'h00A8, "reset pins");
    $display("test reset done");
    clk_run <= 1'b1;
    foreach (cv[i]) begin
      v = cv[i];
      wr_ok(`IDX_DEV_CTRL, v);
      rd_chk(`IDX_DEV_CTRL, 32'(v & 8'h9F), "ctrl readback");
      chk_word(32'(ctl_pins), 32'({v[7], v[4], v[3], v[2], v[1]}), "ctrl pins");
      seen = 0;
      repeat (30) @(posedge aclk) seen |= returned_serial_clock;
      chk_word(32'(seen), 32'(v[0]), "echo");
    end
    clk_run <= 1'b0;
    $display("test control done");
    foreach (fv[i]) begin
      v = fv[i];
      oversample_mode <= i[0];
      wr_ok(`IDX_OUT_FMT, v);
      rd_chk(`IDX_OUT_FMT, 32'(v & 8'h07), "fmt readback");
      chk_word(32'({fixed_pattern_enable, packet_size}), 32'(v[2:0]), "fmt pins");
      chk_word(32'(packet_layout), 32'({i[0], v[2], v[0]}), "layout");
    end
    wr(8'h90, 8'h55, r);
    chk_resp(r, `RESP_SLVERR, "unmapped write");
    rd(8'h90, d, r);
    chk_resp(r, `RESP_SLVERR, "unmapped read");
    chk_word(d, 32'h0, "unmapped data");
    $display("test format done");
    img[8'h25] = 8'h11;
    img[8'h26] = 8'h01;
    for (int i = 8'h27; i <= 8'h71; i++) begin
      img[i] = 8'(i * 7 + 3);
      wr_ok(8'(i), img[i]);
    end
    crc = 16'hFFFF;
    for (int i = 8'h71; i >= 8'h25; i--) crc = crc_step(crc, img[i]);
    wr_ok(`IDX_CRC_LO, crc[7:0]);
    wr_ok(`IDX_CRC_HI, crc[15:8]);
    rd_chk(`IDX_CRC_HI, 32'(crc[15:8]), "ref readback");
    wr_ok(`IDX_IRQ_EN, 8'h30);
    repeat (400) @(posedge aclk);
    wr_ok(`IDX_IRQ_CLR, 8'h30);
    repeat (400) @(posedge aclk);
    rd_chk(`IDX_STATUS, 32'h00, "clean map");
    chk_word(32'(irq), 32'h0, "irq idle");
    wr_ok(8'h40, ~img[8'h40]);
    repeat (400) @(posedge aclk);
    rd_chk(`IDX_STATUS, 32'h10, "corrupt map");
    chk_word(32'(irq), 32'h1, "irq raised");
    wr_ok(`IDX_IRQ_EN, 8'h00);
    repeat (2) @(posedge aclk);
    chk_word(32'(irq), 32'h0, "irq masked");
    wr_ok(8'h40, img[8'h40]);
    repeat (400) @(posedge aclk);
    wr_ok(`IDX_IRQ_CLR, 8'h30);
    rd_chk(`IDX_STATUS, 32'h00, "flag cleared");
    $display("test checksum done");
    wr_ok(`IDX_IRQ_EN, 8'h30);
    wr_ok(`IDX_DEV_CTRL, 8'h91);
    repeat (400) @(posedge aclk);
    rd_chk(`IDX_STATUS, 32'h30, "self test flags");
    wr_ok(`IDX_DEV_CTRL, 8'h11);
    repeat (400) @(posedge aclk);
    wr_ok(`IDX_IRQ_CLR, 8'h30);
    rd_chk(`IDX_STATUS, 32'h00, "self test off");
    fault_req <= 1'b1;
    repeat (5) @(posedge aclk);
    fault_req <= 1'b0;
    repeat (5) @(posedge aclk);
    rd_chk(`IDX_STATUS, 32'h20, "trim fault");
    chk_word(32'(irq), 32'h1, "irq trim");
    wr_ok(`IDX_IRQ_CLR, 8'h20);
    repeat (2) @(posedge aclk);
    chk_word(32'(irq), 32'h0, "irq cleared");
    $display("test self test done");
    stop_test();
  end
endmodule
`default_nettype wire
